// File: design/cbsc_consts.svh
// Offsets, field positions, reset value and write mask for the context bank control block.
`ifndef CBSC_CONSTS_SVH
`define CBSC_CONSTS_SVH
`define CBSC_SCTLR_OFF 12'h000
`define CBSC_TLBIALL_OFF 12'h004
`define CBSC_STATUS_OFF 12'h008
`define CBSC_SCTLR_RESET 32'h00000000
`define CBSC_SCTLR_WMASK 32'h0000D7FF
`define CBSC_TRANS_HI 15
`define CBSC_TRANS_LO 14
`define CBSC_PRIV_TAG 12
`define CBSC_USER_WRITE_EXEC_NEVER 10
`define CBSC_WXN 9
`define CBSC_HUF 8
`define CBSC_STALL 7
`define CBSC_IRQEN 6
`define CBSC_ABTEN 5
`define CBSC_ENDIAN 4
`define CBSC_ACCESS_FLAG_FAULT_DISABLE 3
`define CBSC_AFE 2
`define CBSC_TRE 1
`define CBSC_EN 0
`endif

// File: design/cbsc_pkg.sv
// Types shared by the context bank control block.
package cbsc_pkg;
  // Transient hint encodings.
  typedef enum logic [1:0]
  {
    CBSC_TR_DEFAULT = 2'h0,
    CBSC_TR_RSVD = 2'h1,
    CBSC_TR_NONTRANS = 2'h2,
    CBSC_TR_TRANS = 2'h3
  } cbsc_trans_t;

  // Incoming transaction descriptor, after table lookup.
  typedef struct packed
  {
    logic fetch;
    logic exclusive;
    logic writable;
    logic user_writable;
    logic ap0;
    logic [2:0] type_ext_bits;
    logic c;
    logic b;
    logic [1:0] tr_in;
  } cbsc_req_t;

  // Outcome of the checks for one transaction.
  typedef struct packed
  {
    logic translated;
    logic perm_fault;
    logic af_fault;
    logic abort;
    logic excl_fail;
    logic stall;
    logic big_endian;
    logic full_perm;
    logic [4:0] attr;
    logic [1:0] sw_flags;
    logic [1:0] tr_out;
    logic priv_tag;
  } cbsc_rsp_t;
endpackage : cbsc_pkg

// File: design/cbsc_top.sv
// Context bank system control register and per-transaction control checks.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cbsc_consts.svh"

// Functional notes
// R01: Transient field 00 default, 01 reserved, 10 non-transient, 11 transient.
// R02: Transient override used only when bypassed; absent field reads zero.
// R03: Private tag hint bit is stored and read back; else only exported.
// R04: Broadcast invalidate may skip entries allocated with private hint.
// R05: User write-exec-never faults fetches from user-writable locations.
// R06: Write-exec-never faults fetches from any writable location.
// R07: Execute-never checks apply only to translated transactions.
// R08: Without hit-under-fault, later transactions wait while a fault is outstanding.
// R09: Fault stall select: zero terminates, one stalls the faulting transaction.
// R10: Interrupt enable resets zero; when set every context fault raises interrupt.
// R11: Abort enable resets zero; when set a fault returns abort.
// R12: Faulting exclusive access with abort disabled is reported as failed.
// R13: Endian bit selects little (0) or big (1) table entries.
// R14: Access flag clear faults unless fault disable set, then treated set.
// R15: Access flag enable makes permission bit0 a flag, simplified model.
// R16: Long-descriptor format forces access flag and remap enables on.
// R17: Remap off uses all type bits; remap on frees upper two as flags.
// R18: Translation enable on/off, never cached in TLB entries.
// R19: Transactions after a completed enable write use the new value.
// R20: Full invalidate after disable waits for translated transactions to finish.
// R21: Software should do TLB maintenance after changing fault-disable bit.
// R22: User write-exec-never may read zero when short formats unsupported.
module cbsc_top
  import cbsc_pkg::*;
#(
  parameter bit HAS_TRANSIENT = 1'b1,
  parameter bit HAS_SHORT_FMT = 1'b1,
  parameter int INFLIGHT_W = 4
)
(
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // APB slave.
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [31:0] PRDATA_OUT,
  // Format selection from the translation control register.
  input wire logic LONG_DESC_IN,
  // Transaction request and result.
  input wire logic REQ_VALID_IN,
  input wire cbsc_req_t REQ_IN,
  output logic REQ_READY_OUT,
  output logic RSP_VALID_OUT,
  output cbsc_rsp_t RSP_OUT,
  // Completion of one transaction processed while translated.
  input wire logic XLAT_DONE_IN,
  // Software resolution of an outstanding context fault.
  input wire logic FAULT_CLEAR_IN,
  // Fault indication and status.
  output logic FAULT_IRQ_OUT,
  output logic FAULT_PENDING_OUT,
  output logic INVAL_BUSY_OUT
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] wmask;
  logic apb_wr;
  logic apb_rd;
  logic fault_q;
  logic [INFLIGHT_W-1:0] inflight_q;
  logic inval_q;
  logic req_fire;
  logic fault_now;

  // Writable mask trims absent optional fields so they read zero.
  always_comb
  begin
    wmask = `CBSC_SCTLR_WMASK;
    // R02: absent transient field
    if (!HAS_TRANSIENT)
    begin
      wmask[`CBSC_TRANS_HI:`CBSC_TRANS_LO] = 2'h0;
    end
    // R22: absent user xn
    if (!HAS_SHORT_FMT)
    begin
      wmask[`CBSC_USER_WRITE_EXEC_NEVER] = 1'b0;
    end
  end

  // APB accesses complete in their first access cycle; read data is loaded in setup.
  assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign apb_rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;

  // Control register, all fields reset to zero.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      // R10: irq enable resets zero
      // R11: abort enable resets zero
      ctrl_q <= `CBSC_SCTLR_RESET;
    end
    else if (apb_wr && PADDR_IN == `CBSC_SCTLR_OFF)
    begin
      // R03: hint stored for readback
      ctrl_q <= PWDATA_IN & wmask;
    end
  end

  // Unmapped addresses answer with an error.
  always_comb
  begin
    PSLVERR_OUT = 1'b0;
    if (PSEL_IN && PENABLE_IN)
    begin
      PSLVERR_OUT = !(PADDR_IN == `CBSC_SCTLR_OFF || PADDR_IN == `CBSC_TLBIALL_OFF ||
                      PADDR_IN == `CBSC_STATUS_OFF) ||
                    (PWRITE_IN && PADDR_IN == `CBSC_STATUS_OFF);
    end
  end

  // Read data register, loaded in the setup cycle so it stands at the access edge.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      PRDATA_OUT <= 32'h00000000;
    end
    else if (apb_rd)
    begin
      unique case (PADDR_IN)
        `CBSC_SCTLR_OFF: PRDATA_OUT <= ctrl_q;
        `CBSC_STATUS_OFF: PRDATA_OUT <= {30'h00000000, inval_q, fault_q};
        default: PRDATA_OUT <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Transaction checks
  // ------------------------------------------------------------
  logic en;
  logic afe_eff;
  logic tre_eff;
  logic ap0_eff;
  logic xn_fault;
  logic hold;

  // R18: enable read live each time
  // R19: new value used at once
  assign en = ctrl_q[`CBSC_EN];
  // R16: long format forces enables
  assign afe_eff = ctrl_q[`CBSC_AFE] || LONG_DESC_IN;
  assign tre_eff = ctrl_q[`CBSC_TRE] || LONG_DESC_IN;
  // R14: fault disable forces flag
  assign ap0_eff = REQ_IN.ap0 || ctrl_q[`CBSC_ACCESS_FLAG_FAULT_DISABLE];

  // R05: user writable fetch fault
  // R06: writable fetch fault
  // R07: only when translated
  assign xn_fault = en && REQ_IN.fetch &&
                    ((ctrl_q[`CBSC_WXN] && REQ_IN.writable) ||
                     (ctrl_q[`CBSC_USER_WRITE_EXEC_NEVER] && REQ_IN.user_writable));

  // R08: block later traffic on fault
  assign hold = fault_q && !ctrl_q[`CBSC_HUF];
  assign REQ_READY_OUT = !hold;
  assign req_fire = REQ_VALID_IN && REQ_READY_OUT;
  // R14: access flag fault
  assign fault_now = req_fire && (xn_fault || (en && afe_eff && !ap0_eff));

  // Result register for each accepted transaction.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      RSP_VALID_OUT <= 1'b0;
      RSP_OUT <= '0;
    end
    else
    begin
      RSP_VALID_OUT <= req_fire;
      if (req_fire)
      begin
        RSP_OUT.translated <= en;
        RSP_OUT.perm_fault <= xn_fault;
        RSP_OUT.af_fault <= en && afe_eff && !ap0_eff;
        // R11: abort on fault
        RSP_OUT.abort <= fault_now && ctrl_q[`CBSC_ABTEN];
        // R12: exclusive reported failed
        RSP_OUT.excl_fail <= fault_now && !ctrl_q[`CBSC_ABTEN] && REQ_IN.exclusive;
        // R09: stall or terminate
        RSP_OUT.stall <= fault_now && ctrl_q[`CBSC_STALL];
        // R13: table endianness
        RSP_OUT.big_endian <= ctrl_q[`CBSC_ENDIAN];
        // R15: full model without flag
        RSP_OUT.full_perm <= !afe_eff;
        // R17: remap selects attributes
        if (tre_eff)
        begin
          RSP_OUT.attr <= {2'h0, REQ_IN.type_ext_bits[0], REQ_IN.c, REQ_IN.b};
          RSP_OUT.sw_flags <= REQ_IN.type_ext_bits[2:1];
        end
        else
        begin
          RSP_OUT.attr <= {REQ_IN.type_ext_bits, REQ_IN.c, REQ_IN.b};
          RSP_OUT.sw_flags <= 2'h0;
        end
        // R01: transient override
        // R02: bypass only
        if (!en && ctrl_q[`CBSC_TRANS_HI])
        begin
          RSP_OUT.tr_out <= ctrl_q[`CBSC_TRANS_HI:`CBSC_TRANS_LO];
        end
        else
        begin
          RSP_OUT.tr_out <= REQ_IN.tr_in;
        end
        // R04: hint marks tag entries
        RSP_OUT.priv_tag <= ctrl_q[`CBSC_PRIV_TAG];
      end
    end
  end

  // ------------------------------------------------------------
  // Fault state and interrupt
  // ------------------------------------------------------------
  // Outstanding fault flag; a new fault wins over a clear.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      fault_q <= 1'b0;
    end
    else if (fault_now)
    begin
      fault_q <= 1'b1;
    end
    else if (FAULT_CLEAR_IN)
    begin
      fault_q <= 1'b0;
    end
  end

  // R10: interrupt gated by enable
  assign FAULT_IRQ_OUT = fault_q && ctrl_q[`CBSC_IRQEN];
  assign FAULT_PENDING_OUT = fault_q;

  // ------------------------------------------------------------
  // Invalidate ordering
  // ------------------------------------------------------------
  // Count of translated transactions not yet complete.
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      inflight_q <= '0;
    end
    else
    begin
      unique case ({req_fire && en && !fault_now, XLAT_DONE_IN && inflight_q != '0})
        2'b10: inflight_q <= inflight_q + 1'b1;
        2'b01: inflight_q <= inflight_q - 1'b1;
        default: inflight_q <= inflight_q;
      endcase
    end
  end

  // R20: invalidate waits for drain
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      inval_q <= 1'b0;
    end
    else if (apb_wr && PADDR_IN == `CBSC_TLBIALL_OFF)
    begin
      inval_q <= 1'b1;
    end
    else if (inflight_q == '0)
    begin
      inval_q <= 1'b0;
    end
  end

  assign INVAL_BUSY_OUT = inval_q;

endmodule : cbsc_top

// File: tb/cbsc_top_assertions.sv
// Checker for the context bank control block.
`timescale 1ns/1ps
module cbsc_chk
  import cbsc_pkg::*;
(
  // Watched ports.
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic LONG_DESC_IN,
  input wire logic REQ_VALID_IN,
  input wire cbsc_req_t REQ_IN,
  input wire logic REQ_READY_OUT,
  input wire logic RSP_VALID_OUT,
  input wire cbsc_rsp_t RSP_OUT,
  input wire logic FAULT_IRQ_OUT,
  input wire logic FAULT_PENDING_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // A request taken at an edge.
  sequence take_s;
    REQ_VALID_IN && REQ_READY_OUT;
  endsequence
  // Any fault on the response.
  wire flt = RSP_OUT.perm_fault | RSP_OUT.af_fault;
  resp_next_a: assert property (take_s |=> RSP_VALID_OUT)
    else $error("no response");
  fault_pend_a: assert property (RSP_VALID_OUT && flt |-> FAULT_PENDING_OUT)
    else $error("fault not pending");
  irq_gate_a: assert property (FAULT_IRQ_OUT |-> FAULT_PENDING_OUT)
    else $error("stray interrupt");
  abort_cause_a: assert property (RSP_VALID_OUT && RSP_OUT.abort |-> flt)
    else $error("abort without fault");
  excl_fail_a: assert property (RSP_VALID_OUT && RSP_OUT.excl_fail |-> flt && !RSP_OUT.abort)
    else $error("bad exclusive fail");
  xn_scope_a: assert property (RSP_VALID_OUT && RSP_OUT.perm_fault |-> RSP_OUT.translated)
    else $error("bypass checked");
  stall_cause_a: assert property (RSP_VALID_OUT && RSP_OUT.stall |-> flt)
    else $error("stall without fault");
  af_set_a: assert property ((take_s and REQ_IN.ap0) |=> !RSP_OUT.af_fault)
    else $error("flag fault with flag set");
  long_fmt_a: assert property ((take_s and LONG_DESC_IN) |=> !RSP_OUT.full_perm)
    else $error("long format full model");
endmodule : cbsc_chk
bind cbsc_top cbsc_chk u_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .LONG_DESC_IN(LONG_DESC_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_OUT(RSP_OUT),
  .FAULT_IRQ_OUT(FAULT_IRQ_OUT), .FAULT_PENDING_OUT(FAULT_PENDING_OUT));

// File: tb/cbsc_master.sv
// Upstream master model issuing one transaction per command.
`timescale 1ns/1ps
module cbsc_master
  import cbsc_pkg::*;
(
  // Clock, command and transaction port.
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire cbsc_req_t d_in,
  input wire logic ready_in,
  output logic valid_out,
  output cbsc_req_t req_out
);
  // Hold the request until taken, then scramble the released fields.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      valid_out <= 1'b0;
      req_out <= '0;
    end
    else if (go_in)
    begin
      valid_out <= 1'b1;
      req_out <= d_in;
    end
    else if (valid_out && ready_in)
    begin
      valid_out <= 1'b0;
      req_out <= ~req_out;
    end
  end
endmodule : cbsc_master

// File: tb/cbsc_top_tb.sv
// Self-checking bench for the context bank control block.
`timescale 1ns/1ps
module cbsc_top_tb
  import cbsc_pkg::*;
  ;
  logic clk, rstn, psel, pen, pwr, longd, go, xd, fc, prdy, perr, perr_s;
  logic rv, rrdy, sv, irq, pend, busy;
  logic [11:0] padr;
  logic [31:0] pwd, prd, rdat, c;
  logic [31:0] seed = 32'h0000002E;
  logic [3:0] e;
  int err_count = 0;
  int n_checks = 0;
  cbsc_req_t d, rq, r;
  cbsc_rsp_t rsp;
  cbsc_top u_dut (.CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .PRDATA_OUT(prd), .LONG_DESC_IN(longd), .REQ_VALID_IN(rv),
    .REQ_IN(rq), .REQ_READY_OUT(rrdy), .RSP_VALID_OUT(sv), .RSP_OUT(rsp),
    .XLAT_DONE_IN(xd), .FAULT_CLEAR_IN(fc), .FAULT_IRQ_OUT(irq),
    .FAULT_PENDING_OUT(pend), .INVAL_BUSY_OUT(busy));
  cbsc_master u_mst (.clk_in(clk), .rstn_in(rstn), .go_in(go), .d_in(d),
    .ready_in(rrdy), .valid_out(rv), .req_out(rq));
  // Free-running clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Xorshift source.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected perm fault, flag fault and transient code.
  function automatic logic [3:0] exp_f(input logic [31:0] k, input cbsc_req_t q, input logic l);
    logic pf, af;
    pf = k[0] & q.fetch & ((k[9] & q.writable) | (k[10] & q.user_writable));
    af = k[0] & (k[2] | l) & !(q.ap0 | k[3]);
    return {pf, af, (!k[0] && k[15]) ? k[15:14] : q.tr_in};
  endfunction : exp_f
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, s, x);
    end
  endtask : chk
  // Bounded wait on a flag, sampled after each edge.
  task automatic wait_on(ref logic f, input logic v);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (f !== v && n < 60);
    if (n >= 60)
    begin
      err_count++;
      wrap_up();
    end
  endtask : wait_on
  // One register bus transfer.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= v;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 60);
    perr_s = perr;
    rdat = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 60)
    begin
      err_count++;
      wrap_up();
    end
  endtask : apb
  // One transaction through the master model.
  task automatic xact(input cbsc_req_t q, input logic l);
    @(posedge clk);
    d <= q;
    longd <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_on(sv, 1'b1);
  endtask : xact
  // Main sequence.
  initial
  begin
    {rstn, psel, pen, pwr, longd, go, xd, fc} = '0;
    padr = '0;
    pwd = '0;
    d = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    chk(32'(perr_s), 32'h1);
    for (int i = 0; i < 48; i++)
    begin
      c = rnd() & 32'h0000D7FF | 32'h00000100;
      apb(1'b1, 12'h000, c);
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, c);
      r = cbsc_req_t'(rnd());
      e = exp_f(c, r, rnd() & 1);
      xact(r, seed[0]);
      chk(32'({rsp.perm_fault, rsp.af_fault, rsp.tr_out, rsp.abort, rsp.big_endian}),
        32'({e, (e[3] | e[2]) & c[5], c[4]}));
      fc <= 1'b1;
      xd <= c[0] & ~(e[3] | e[2]);
      @(posedge clk);
      fc <= 1'b0;
      xd <= 1'b0;
    end
    $display("test done: random");
    apb(1'b1, 12'h000, 32'h00000241);
    r = '0;
    r.fetch = 1'b1;
    r.writable = 1'b1;
    xact(r, 1'b0);
    chk(32'({rrdy, irq, pend}), 32'h3);
    fc <= 1'b1;
    @(posedge clk);
    fc <= 1'b0;
    wait_on(rrdy, 1'b1);
    apb(1'b1, 12'h000, 32'h00000001);
    xact('0, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    repeat (4) @(posedge clk);
    #1 chk(32'(busy), 32'h1);
    xact('0, 1'b0);
    chk(32'(rsp.translated), 32'h0);
    xd <= 1'b1;
    @(posedge clk);
    xd <= 1'b0;
    wait_on(busy, 1'b0);
    $display("test done: directed");
    wrap_up();
  end
endmodule : cbsc_top_tb
